// [design/ibf_flags.sv]
// bus condition detection and flag register of the i2c unit
//
// Chosen here: the plain strobed port.
`default_nettype none

module ibf_flags
  import ibf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W-1:0] wmask_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic start_gen_o,
  output logic addr_period_o
);

  // ********************************************************
  // line sampling
  // ********************************************************
  logic [2:0] scl_sync_reg, scl_sync_next;
  logic [2:0] sda_sync_reg, sda_sync_next;
  logic scl_f_reg, scl_f_next;
  logic sda_f_reg, sda_f_next;
  logic scl_rise, start_det, stop_det;

  always_comb begin
    scl_sync_next = {scl_sync_reg[1:0], scl_i};
    sda_sync_next = {sda_sync_reg[1:0], sda_i};
    scl_f_next = scl_f_reg;
    sda_f_next = sda_f_reg;
    // a level counts only once the last two stages agree
    if (scl_sync_reg[1] == scl_sync_reg[2]) begin
      scl_f_next = scl_sync_reg[2];
    end
    if (sda_sync_reg[1] == sda_sync_reg[2]) begin
      sda_f_next = sda_sync_reg[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_reg <= SYNC_RST;
      sda_sync_reg <= SYNC_RST;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
    end else if (en_i) begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_f_reg <= scl_f_next;
      sda_f_reg <= sda_f_next;
    end
  end

  // edges are qualified by the filtered levels, so a data change
  // and a clock change in one sample window give neither a start nor a stop
  always_comb begin
    scl_rise = en_i && scl_f_next && !scl_f_reg;
    start_det = en_i && scl_f_reg && scl_f_next && sda_f_reg && !sda_f_next;
    stop_det = en_i && scl_f_reg && scl_f_next && !sda_f_reg && sda_f_next;
  end

  // ********************************************************
  // register decode
  // ********************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic wbit(input logic [DATA_W-1:0] m,
                                input logic [DATA_W-1:0] d,
                                input int pos, input logic old);
    wbit = m[pos] ? d[pos] : old;
  endfunction : wbit

  logic wr_flag, wr_ctrl;
  always_comb begin
    wr_flag = en_i && wr_i && hit(addr_i, FLAG_CTRL_OFS);
    wr_ctrl = en_i && wr_i && hit(addr_i, UNIT_CTRL_OFS);
  end

  // ********************************************************
  // control and flag state
  // ********************************************************
  logic unit_enable_reg, unit_enable_next;
  logic start_request_reg, start_request_next;
  logic start_seen_flag_reg, start_seen_flag_next;
  logic stop_seen_flag_reg, stop_seen_flag_next;
  logic start_fail_flag_reg, start_fail_flag_next;
  logic bus_occupied_flag_reg, bus_occupied_flag_next;
  logic initial_start_permit_reg, initial_start_permit_next;
  logic reservation_off_reg, reservation_off_next;
  logic start_gen_reg, start_gen_next;
  ibf_phase_t phase_reg, phase_next;
  logic [3:0] clk_cnt_reg, clk_cnt_next;
  logic comm_exit_ctl, req_write, en_fall, en_rise;
  logic addr_first_clk, next_byte_clk;

  always_comb begin
    unit_enable_next = unit_enable_reg;
    comm_exit_ctl = 1'b0;
    req_write = 1'b0;
    if (wr_ctrl) begin
      unit_enable_next = wbit(wmask_i, wdata_i, CTL_UNIT_EN_BIT,
                              unit_enable_reg);
      comm_exit_ctl = wmask_i[CTL_COMM_EXIT_BIT] &&
                      wdata_i[CTL_COMM_EXIT_BIT] && unit_enable_reg;
      req_write = wmask_i[CTL_START_REQ_BIT] &&
                  wdata_i[CTL_START_REQ_BIT];
    end
    en_fall = unit_enable_reg && !unit_enable_next;
    en_rise = !unit_enable_reg && unit_enable_next;
  end

  // byte tracking inside the address period
  always_comb begin
    phase_next = phase_reg;
    clk_cnt_next = clk_cnt_reg;
    addr_first_clk = 1'b0;
    next_byte_clk = 1'b0;
    case (phase_reg)
      IBF_IDLE: begin
      end
      IBF_ADDR: begin
        if (scl_rise) begin
          addr_first_clk = (clk_cnt_reg == CLK_CNT_RST);
          clk_cnt_next = clk_cnt_reg + 4'h1;
          if (clk_cnt_next == ADDR_BYTE_CLOCKS) begin
            phase_next = IBF_DATA;
          end
        end
      end
      IBF_DATA: begin
        if (scl_rise) begin
          next_byte_clk = 1'b1;
          phase_next = IBF_IDLE;
        end
      end
      default: begin
        phase_next = IBF_IDLE;
      end
    endcase
    // a repeated start restarts the address byte
    if (start_det && unit_enable_reg) begin
      phase_next = IBF_ADDR;
      clk_cnt_next = CLK_CNT_RST;
    end
    if (stop_det || !unit_enable_reg || comm_exit_ctl) begin
      phase_next = IBF_IDLE;
      clk_cnt_next = CLK_CNT_RST;
    end
  end

  always_comb begin
    start_seen_flag_next = start_seen_flag_reg;
    if (stop_det || next_byte_clk || comm_exit_ctl || en_fall) begin
      start_seen_flag_next = 1'b0;
    end
    // a new start wins over a clear
    if (start_det && unit_enable_reg) begin
      start_seen_flag_next = 1'b1;
    end

    stop_seen_flag_next = stop_seen_flag_reg;
    // cleared at the address first clock
    if (addr_first_clk || en_fall) begin
      stop_seen_flag_next = 1'b0;
    end
    if (stop_det && unit_enable_reg) begin
      stop_seen_flag_next = 1'b1;
    end

    bus_occupied_flag_next = bus_occupied_flag_reg;
    if (stop_det) begin
      bus_occupied_flag_next = 1'b0;
    end
    if ((start_det && unit_enable_reg) ||
        (en_rise && !initial_start_permit_reg)) begin
      bus_occupied_flag_next = 1'b1;
    end
    if (!unit_enable_next) begin
      bus_occupied_flag_next = 1'b0;
    end
  end

  always_comb begin
    initial_start_permit_next = initial_start_permit_reg;
    reservation_off_next = reservation_off_reg;
    if (wr_flag && !unit_enable_reg) begin
      initial_start_permit_next = wbit(wmask_i, wdata_i,
        FLG_INIT_PERMIT_BIT, initial_start_permit_reg);
      reservation_off_next = wbit(wmask_i, wdata_i, FLG_RSV_OFF_BIT,
                                  reservation_off_reg);
    end
    if (start_det && unit_enable_reg) begin
      initial_start_permit_next = 1'b0;
    end
  end

  // with reservation on, a request to a busy bus simply waits here;
  // the reservation engine itself lives elsewhere
  always_comb begin
    start_request_next = start_request_reg;
    start_fail_flag_next = start_fail_flag_reg;
    start_gen_next = 1'b0;
    if (req_write && unit_enable_reg) begin
      start_request_next = 1'b1;
      // a new request clears the fail flag
      start_fail_flag_next = 1'b0;
    end else if (start_request_reg) begin
      // permit leaves the bus free after enabling
      if (!bus_occupied_flag_reg) begin
        start_gen_next = 1'b1;
        start_request_next = 1'b0;
      end else if (reservation_off_reg) begin
        // failed start clears request, sets fail
        start_request_next = 1'b0;
        start_fail_flag_next = 1'b1;
      end
    end
    if (!unit_enable_next) begin
      start_request_next = 1'b0;
      start_gen_next = 1'b0;
      start_fail_flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_enable_reg <= 1'b0;
      start_request_reg <= 1'b0;
      start_seen_flag_reg <= 1'b0;
      stop_seen_flag_reg <= 1'b0;
      start_fail_flag_reg <= FLAG_CTRL_RST[FLG_START_FAIL_BIT];
      bus_occupied_flag_reg <= FLAG_CTRL_RST[FLG_BUS_OCC_BIT];
      initial_start_permit_reg <= FLAG_CTRL_RST[FLG_INIT_PERMIT_BIT];
      reservation_off_reg <= FLAG_CTRL_RST[FLG_RSV_OFF_BIT];
      start_gen_reg <= 1'b0;
      phase_reg <= IBF_IDLE;
      clk_cnt_reg <= CLK_CNT_RST;
    end else if (en_i) begin
      unit_enable_reg <= unit_enable_next;
      start_request_reg <= start_request_next;
      start_seen_flag_reg <= start_seen_flag_next;
      stop_seen_flag_reg <= stop_seen_flag_next;
      start_fail_flag_reg <= start_fail_flag_next;
      bus_occupied_flag_reg <= bus_occupied_flag_next;
      initial_start_permit_reg <= initial_start_permit_next;
      reservation_off_reg <= reservation_off_next;
      start_gen_reg <= start_gen_next;
      phase_reg <= phase_next;
      clk_cnt_reg <= clk_cnt_next;
    end
  end

  // ********************************************************
  // read path
  // ********************************************************
  logic [DATA_W-1:0] rdata_reg, rdata_next;

  // flag bits read back, not written
  always_comb begin
    rdata_next = READ_NONE;
    if (rd_i) begin
      if (hit(addr_i, FLAG_CTRL_OFS)) begin
        // bits five to two stay zero
        rdata_next[FLG_START_FAIL_BIT] = start_fail_flag_reg;
        rdata_next[FLG_BUS_OCC_BIT] = bus_occupied_flag_reg;
        rdata_next[FLG_INIT_PERMIT_BIT] = initial_start_permit_reg;
        rdata_next[FLG_RSV_OFF_BIT] = reservation_off_reg;
      end else if (hit(addr_i, UNIT_CTRL_OFS)) begin
        rdata_next[CTL_UNIT_EN_BIT] = unit_enable_reg;
        rdata_next[CTL_START_REQ_BIT] = start_request_reg;
      end else if (hit(addr_i, UNIT_STAT_OFS)) begin
        rdata_next[STS_START_SEEN_BIT] = start_seen_flag_reg;
        rdata_next[STS_STOP_SEEN_BIT] = stop_seen_flag_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= READ_NONE;
    end else if (en_i) begin
      rdata_reg <= rdata_next;
    end
  end

  always_comb begin
    rdata_o = rdata_reg;
    start_gen_o = start_gen_reg;
    addr_period_o = start_seen_flag_reg;
  end

endmodule : ibf_flags
`default_nettype wire

// [design/ibf_pkg.sv]
// package of constants and types for the i2c bus condition flag block
`default_nettype none
package ibf_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam int ADDR_W = 28;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] FLAG_CTRL_OFS = 28'hFFFFD8A;
  localparam logic [ADDR_W-1:0] UNIT_CTRL_OFS = 28'hFFFFD82;
  localparam logic [ADDR_W-1:0] UNIT_STAT_OFS = 28'hFFFFD86;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int FLG_START_FAIL_BIT = 7;
  localparam int FLG_BUS_OCC_BIT = 6;
  localparam int FLG_INIT_PERMIT_BIT = 1;
  localparam int FLG_RSV_OFF_BIT = 0;
  localparam int CTL_UNIT_EN_BIT = 7;
  localparam int CTL_COMM_EXIT_BIT = 6;
  localparam int CTL_START_REQ_BIT = 1;
  localparam int STS_START_SEEN_BIT = 1;
  localparam int STS_STOP_SEEN_BIT = 0;

  // ********************************************************
  // reset values and counts
  // ********************************************************
  localparam logic [DATA_W-1:0] FLAG_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] READ_NONE = 8'h00;
  localparam logic [3:0] ADDR_BYTE_CLOCKS = 4'h9;
  localparam logic [3:0] CLK_CNT_RST = 4'h0;
  localparam logic [2:0] SYNC_RST = 3'h7;

  // ********************************************************
  // byte phase after a start condition
  // ********************************************************
  typedef enum logic [1:0] {
    IBF_IDLE = 2'h0,
    IBF_ADDR = 2'h1,
    IBF_DATA = 2'h3
  } ibf_phase_t;

endpackage : ibf_pkg
`default_nettype wire

// [tb/ibf_monitor.sv]
// port checker of the i2c bus condition flag block
`default_nettype none
module ibf_monitor
  import ibf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W-1:0] wmask_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic start_gen_o,
  input wire logic addr_period_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****
  // sequences
  // ****
  sequence flag_rd_s;
    rd_i && addr_i == FLAG_CTRL_OFS;
  endsequence
  sequence nomap_rd_s;
    rd_i && addr_i != FLAG_CTRL_OFS && addr_i != UNIT_CTRL_OFS
      && addr_i != UNIT_STAT_OFS;
  endsequence
  // the line filter needs three cycles or more
  sequence start_cond_s;
    !$past(sda_i, 3) && $past(scl_i, 3);
  endsequence
  // ****
  // assertions
  // ****
  reset_state_a: assert property ($fell(rst_i) |->
    rdata_o == READ_NONE && !addr_period_o && !start_gen_o)
    else $error("state not clear after reset");
  read_idle_a: assert property (!$past(rd_i) |->
    rdata_o == READ_NONE) else $error("read data outside read");
  nomap_zero_a: assert property (nomap_rd_s |=>
    rdata_o == READ_NONE) else $error("unmapped read not zero");
  reserved_zero_a: assert property (flag_rd_s |=>
    rdata_o[5:2] == 4'h0) else $error("reserved bits not zero");
  busy_seen_a: assert property (flag_rd_s ##0 addr_period_o
    |=> rdata_o[FLG_BUS_OCC_BIT]) else $error("start seen, bus free");
  seen_set_a: assert property ($rose(addr_period_o) |->
    start_cond_s) else $error("start seen without start");
  seen_clear_a: assert property ($fell(addr_period_o) |->
    $past(scl_i, 3) || $past(wr_i)) else $error("bad start clear");
  gen_pulse_a: assert property (start_gen_o |=>
    !start_gen_o) else $error("start pulse too long");
  gen_free_a: assert property ($rose(start_gen_o) |->
    !addr_period_o) else $error("start made on busy bus");
endmodule : ibf_monitor
bind ibf_flags ibf_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
  .en_i(en_i), .addr_i(addr_i), .wdata_i(wdata_i), .wmask_i(wmask_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i),
  .sda_i(sda_i), .start_gen_o(start_gen_o),
  .addr_period_o(addr_period_o));
`default_nettype wire

// [tb/ibf_bus_model.sv]
// i2c bus master model driving the serial lines
`default_nettype none
module ibf_bus_model (
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // frames; lines idle high by pull-up, clock still between frames
  // ****
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one ns offset keeps line changes off the system clock edge
  task automatic start();
    #1 sda_o = 1'b0;
    #24 scl_o = 1'b0;
  endtask : start
  // nine clocks of 48 ns, msb first, last slot is the ack
  task automatic bits(input logic [8:0] b);
    #1;
    for (int i = 8; i >= 0; i--) begin
      sda_o = b[i];
      #12 scl_o = 1'b1;
      #24 scl_o = 1'b0;
      #12;
    end
  endtask : bits
  task automatic stop();
    #1 sda_o = 1'b0;
    #12 scl_o = 1'b1;
    #24 sda_o = 1'b1;
    #24;
  endtask : stop
endmodule : ibf_bus_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the i2c bus condition flag block
`default_nettype none
module testbench
  import ibf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [ADDR_W-1:0] FLG = FLAG_CTRL_OFS;
  localparam logic [ADDR_W-1:0] CTL = UNIT_CTRL_OFS;
  localparam logic [ADDR_W-1:0] STS = UNIT_STAT_OFS;
  localparam logic [ADDR_W-1:0] NOMAP = 28'hFFFFD8B;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [DATA_W-1:0] wmask_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_q = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic scl_i;
  logic sda_i;
  logic start_gen_o;
  logic addr_period_o;
  logic [DATA_W-1:0] exp_q[$];
  int failures = 0;
  int num_checks = 0;
  int gens = 0;
  int cyc = 0;
  ibf_flags i_ibf_flags (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wmask_i(wmask_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i), .sda_i(sda_i),
    .start_gen_o(start_gen_o), .addr_period_o(addr_period_o));
  ibf_bus_model i_ibf_bus_model (.scl_o(scl_i), .sda_o(sda_i));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // reads note d as the expected data
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wmask_i <= m;
    if (w) begin
      wr_i <= 1'b1;
    end else begin
      rd_i <= 1'b1;
      exp_q.push_back(d);
    end
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : acc
  task automatic gap();
    repeat (10) @(posedge clk_i);
  endtask : gap
  task automatic summarize();
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  // ****
  // watcher and timeout
  // ****
  always @(posedge clk_i) begin
    if (rd_q) begin
      chk("rdata", exp_q.pop_front(), rdata_o);
    end
    if (start_gen_o === 1'b1) begin
      gens++;
    end
    rd_q <= rd_i;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(26));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, FLG, 8'h00, 8'hFF);
    acc(0, STS, 8'h00, 8'hFF);
    acc(1, NOMAP, 8'($urandom), 8'hFF);
    acc(0, NOMAP, 8'h00, 8'hFF);
    acc(1, FLG, 8'hFF, 8'hFF);
    acc(0, FLG, 8'h03, 8'hFF);
    acc(1, FLG, 8'h00, 8'h01);
    acc(0, FLG, 8'h02, 8'hFF);
    acc(1, FLG, 8'h01, 8'h01);
    acc(1, CTL, 8'h80, 8'hFF);
    acc(1, FLG, 8'($urandom), 8'hFF);
    acc(0, FLG, 8'h03, 8'hFF);
    // bus known idle before the first permitted start
    acc(1, CTL, 8'h82, 8'hFF);
    gap();
    chk("start_gen", 8'h01, 8'(gens));
    i_ibf_bus_model.start();
    gap();
    chk("addr_period", 8'h01, 8'(addr_period_o));
    acc(0, STS, 8'h02, 8'hFF);
    acc(0, FLG, 8'h41, 8'hFF);
    acc(1, CTL, 8'h82, 8'hFF);
    gap();
    acc(0, FLG, 8'hC1, 8'hFF);
    i_ibf_bus_model.bits(9'h0A0);
    gap();
    acc(0, STS, 8'h02, 8'hFF);
    i_ibf_bus_model.bits(9'h000);
    acc(0, STS, 8'h00, 8'hFF);
    chk("addr_period", 8'h00, 8'(addr_period_o));
    i_ibf_bus_model.stop();
    gap();
    acc(0, STS, 8'h01, 8'hFF);
    acc(0, FLG, 8'h81, 8'hFF);
    i_ibf_bus_model.start();
    i_ibf_bus_model.bits(9'h0A0);
    gap();
    acc(0, STS, 8'h02, 8'hFF);
    acc(1, CTL, 8'hC0, 8'hFF);
    acc(0, STS, 8'h00, 8'hFF);
    acc(1, CTL, 8'h00, 8'hFF);
    acc(0, FLG, 8'h01, 8'hFF);
    acc(1, FLG, 8'h00, 8'hFF);
    acc(0, FLG, 8'h00, 8'hFF);
    acc(1, CTL, 8'h80, 8'hFF);
    acc(0, FLG, 8'h40, 8'hFF);
    acc(1, CTL, 8'h82, 8'hFF);
    gap();
    chk("start_gen", 8'h01, 8'(gens));
    i_ibf_bus_model.stop();
    gap();
    chk("start_gen", 8'h02, 8'(gens));
    acc(0, FLG, 8'h00, 8'hFF);
    gap();
    // clock enable low: the disabling write below must not land
    en_i <= 1'b0;
    acc(1, CTL, 8'h00, 8'hFF);
    en_i <= 1'b1;
    acc(0, CTL, 8'h80, 8'hFF);
    acc(1, CTL, 8'h00, 8'hFF);
    acc(1, FLG, 8'h03, 8'hFF);
    acc(0, FLG, 8'h03, 8'hFF);
    // reset in mid-run from a non-zero flag register
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, FLG, 8'h00, 8'hFF);
    acc(0, CTL, 8'h00, 8'hFF);
    gap();
    summarize();
  end
endmodule : testbench
`default_nettype wire
